/* pkg/cpm_pkg.sv */
// cpu power-mode control: shared constants, register map and state types
// assumes a 32-bit axi4-lite register bus and a single 250 MHz clock
package cpm_pkg;

   // ------------------------------------------------------------
   // register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] CPM_ADDR_DOZE = 8'h00;   // doze and idle control
   localparam logic [7:0] CPM_ADDR_VREG = 8'h04;   // regulator control
   localparam logic [7:0] CPM_ADDR_STAT = 8'h08;   // status flags and mode
   localparam logic [7:0] CPM_ADDR_IEN  = 8'h0c;   // interrupt enables

   // doze register fields
   localparam int CPM_IDLE_BIT = 7;
   localparam int CPM_DOZE_ENABLE_BIT = 6;
   localparam int CPM_ROI_BIT = 5;
   localparam int CPM_SOR_BIT = 4;
   localparam int CPM_RATIO_LSB = 0;
   localparam int CPM_RATIO_W = 3;

   // regulator register fields; bit 0 is reserved and reads one
   localparam int CPM_LPSEL_BIT = 1;
   localparam logic [31:0] CPM_VREG_RSVD = 32'h0000_0001;

   // status register fields
   localparam int CPM_PD_BIT = 0;
   localparam int CPM_TO_BIT = 1;
   localparam int CPM_MODE_LSB = 4;

   // interrupt sources and widths
   localparam int CPM_NIRQ = 8;
   localparam int CPM_CNT_W = 8;

   // reset values
   localparam logic [7:0] CPM_DOZE_RST = 8'h00;
   localparam logic CPM_LPSEL_RST = 1'b0;
   localparam logic [CPM_NIRQ-1:0] CPM_IEN_RST = 8'h00;

   // axi responses
   localparam logic [1:0] CPM_RESP_OK = 2'b00;
   localparam logic [1:0] CPM_RESP_ERR = 2'b10;

   // extra regulator settle after low-power sleep
   localparam int CPM_LP_SETTLE_NS = 200;
   localparam int CPM_CLK_NS = 4;
   localparam int CPM_LP_SETTLE_CYC = (CPM_LP_SETTLE_NS + CPM_CLK_NS - 1) / CPM_CLK_NS;

   // power-mode states
   typedef enum logic [2:0] {
      CPM_RUN    = 3'b000,   // normal or doze execution
      CPM_SLEEP  = 3'b001,   // cpu clock gated, oscillators alive
      CPM_IDLE   = 3'b010,   // cpu and flash halted, peripherals alive
      CPM_SETTLE = 3'b011,   // regulator settle after low-power sleep
      CPM_WREADY = 3'b100    // waiting for flash, oscillator, brown-out
   } cpm_state_t;

   // doze ratio less one
   function automatic logic [CPM_CNT_W-1:0] cpm_ratio_last(input logic [CPM_RATIO_W-1:0] sel);
      logic [CPM_CNT_W:0] full;
      full = 9'h002 << sel;
      cpm_ratio_last = CPM_CNT_W'(full - 9'h001);
   endfunction : cpm_ratio_last

endpackage : cpm_pkg

/* verilog/cpm_doze_gen.sv */
// cpu power-mode control: doze cycle enable generator
// assumes a single clock; the ratio select arrives from the register file
`timescale 1ns/1ps
module cpm_doze_gen
   import cpm_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire logic                   dozeOn,     // doze active
   input  wire logic [CPM_RATIO_W-1:0] ratioSel,   // ratio select
   output logic                        cpuCycleEn  // one cycle in n
);

   logic [CPM_CNT_W-1:0] cnt_ff;   // free-running divider

   // ------------------------------------------------------------
   // divider
   // ------------------------------------------------------------
   // free-running count wraps at the selected ratio
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_ff <= '0;
      end else if (cnt_ff >= cpm_ratio_last(ratioSel)) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= cnt_ff + 8'h01;
      end
   end

   // full speed unless doze; else one cycle per wrap
   assign cpuCycleEn = !dozeOn || (cnt_ff == '0);

endmodule : cpm_doze_gen

/* verilog/cpm_wake_delay.sv */
// cpu power-mode control: wake-up settle timer
// assumes start is a one-cycle pulse; done pulses at the end
`timescale 1ns/1ps
module cpm_wake_delay
   import cpm_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic start,   // begin counting
   output logic      done     // one-cycle pulse at the end
);

   logic [15:0] cnt_ff;   // remaining cycles
   logic        run_ff;   // counting

   // ------------------------------------------------------------
   // countdown
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_ff <= '0;
         run_ff <= 1'b0;
      end else if (start) begin
         cnt_ff <= 16'(CPM_LP_SETTLE_CYC - 1);
         run_ff <= 1'b1;
      end else if (run_ff && cnt_ff != '0) begin
         cnt_ff <= cnt_ff - 16'h0001;
      end else begin
         run_ff <= 1'b0;
      end
   end

   assign done = run_ff && (cnt_ff == '0);

endmodule : cpm_wake_delay

/* verilog/cpm_power_ctrl.sv */
// cpu power-mode control: top level with axi4-lite registers and mode fsm
// assumes the cpu sequencer signals instruction events as one-cycle pulses
// and that the brown-out detector, oscillators and flash report readiness as levels
//
// Contract
// - doze runs one cpu cycle in n
// - ratio field selects 1:2 up to 1:256
// - flash prefetch and peripheral clocks keep running
// - finish multicycle instruction before vector fetch
// - cleared enable skips vector, still ends doze
// - recover clear keeps service routine at doze rate
// - recover set clears doze, runs prefetched, vectors
// - slow-on-return sets doze on return instruction
// - sleep instruction with idle clear enters sleep
// - sleep entry clears watchdog count
// - sleep entry clears powerdown, sets timeout flag
// - sleep gates cpu clock, oscillators stay on
// - io ports hold state in sleep
// - resets wake with reset, interrupts without
// - individual enable wakes; global enable picks vectoring
// - watchdog cleared on every wake from sleep
// - resume only when flash, oscillator, brownout ready
// - pending interrupt turns sleep into no-op
// - interrupt during sleep wakes, clears, updates flags
// - low-power sleep adds wake settle delay
// - idle select makes sleep enter idle
// - any interrupt leaves idle, select unchanged; here clock-switch sources (clkSwitchMask) do not end idle
// - recover set ends doze on idle exit
// - watchdog in idle wakes, doze untouched
//
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module cpm_power_ctrl
   import cpm_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                rst,
   // axi4-lite slave
   input  wire logic [7:0]          s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [7:0]          s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   // cpu sequencer
   input  wire logic                sleepInstr,      // sleep executes, pulse
   input  wire logic                retFromIrq,      // return_from_irq, pulse
   input  wire logic                multiCycleBusy,  // multicycle instr running
   input  wire logic                prefetchClrEn,   // prefetched instr clears enable
   input  wire logic                globalIrqEnable, // global_irq_enable
   output logic                     cpuCycleEn,      // cpu may run this cycle
   output logic                     cpuClkEn,        // cpu clock gate
   output logic                     flashFetchEn,    // program_flash prefetch enable
   output logic                     periphClkEn,     // peripheral clocks
   output logic                     vectorReq,       // fetch vector, pulse
   output logic                     ioHold,          // freeze io port state
   // interrupt controller
   input  wire logic [CPM_NIRQ-1:0] irqFlag,         // source flags
   input  wire logic [CPM_NIRQ-1:0] clkSwitchMask,   // clock-switch sources
   // watchdog
   input  wire logic                wdtTimeout,      // watchdog expiry, pulse
   input  wire logic                wdtSleepRun,     // enabled in sleep
   output logic                     wdtClear,        // clear count and prescaler
   output logic                     wdtRun,          // watchdog may count
   output logic                     wdtResetReq,     // watchdog reset, pulse
   // readiness
   input  wire logic                flashReady,
   input  wire logic                oscReady,
   input  wire logic                brownoutReady,
   input  wire logic                brownoutDisabled
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic                   idleSel_ff;        // idle_select
   logic                   dozeEn_ff;         // doze_enable
   logic                   recoverOnIrq_ff;   // recover_on_irq
   logic                   slowOnReturn_ff;   // slow_on_return
   logic [CPM_RATIO_W-1:0] ratio_ff;          // cpu_rate_ratio
   logic                   lpSel_ff;          // regulator_lowpower_sel
   logic [CPM_NIRQ-1:0]    ien_ff;            // per-source enables
   logic                   pdN_ff;            // powerdown_flag_n
   logic                   toN_ff;            // timeout_flag_n
   logic                   pending_ff;        // registered pending
   logic                   vecPend_ff;        // vector owed after prefetch
   cpm_state_t             state_ff;
   logic                   wdtClr_ff;

   // axi bookkeeping
   logic                   awHeld_ff, wHeld_ff;
   logic [7:0]             awAddr_ff;
   logic [31:0]            wData_ff;
   logic [3:0]             wStrb_ff;

   // ------------------------------------------------------------
   // interrupt pending
   // ------------------------------------------------------------
   // sampled on clk; clock switch cannot wake
   logic [CPM_NIRQ-1:0] active;
   logic                wakeIrq;
   assign active = irqFlag & ien_ff;
   always_ff @(posedge clk) begin
      if (rst) pending_ff <= 1'b0;
      else     pending_ff <= |active;
   end
   assign wakeIrq = |(active & ~clkSwitchMask);

   // ------------------------------------------------------------
   // axi write path
   // ------------------------------------------------------------
   logic doWrite;
   assign s_axi_awready = !awHeld_ff && !s_axi_bvalid;
   assign s_axi_wready  = !wHeld_ff && !s_axi_bvalid;
   assign doWrite = awHeld_ff && wHeld_ff && !s_axi_bvalid;

   // aw and w in either order; hold until both
   always_ff @(posedge clk) begin
      if (rst) begin
         awHeld_ff <= 1'b0;
         wHeld_ff  <= 1'b0;
         awAddr_ff <= '0;
         wData_ff  <= '0;
         wStrb_ff  <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_ff <= 1'b1;
            awAddr_ff <= s_axi_awaddr;
         end else if (doWrite) begin
            awHeld_ff <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_ff <= 1'b1;
            wData_ff <= s_axi_wdata;
            wStrb_ff <= s_axi_wstrb;
         end else if (doWrite) begin
            wHeld_ff <= 1'b0;
         end
      end
   end

   // write response; unmapped addresses answer slverr
   always_ff @(posedge clk) begin
      if (rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= CPM_RESP_OK;
      end else if (doWrite) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (awAddr_ff == CPM_ADDR_DOZE || awAddr_ff == CPM_ADDR_VREG ||
                          awAddr_ff == CPM_ADDR_STAT || awAddr_ff == CPM_ADDR_IEN)
                         ? CPM_RESP_OK : CPM_RESP_ERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   logic wrDoze, wrVreg, wrIen;
   assign wrDoze = doWrite && awAddr_ff == CPM_ADDR_DOZE && wStrb_ff[0];
   assign wrVreg = doWrite && awAddr_ff == CPM_ADDR_VREG && wStrb_ff[0];
   assign wrIen  = doWrite && awAddr_ff == CPM_ADDR_IEN && wStrb_ff[0];

   // ------------------------------------------------------------
   // mode fsm and events
   // ------------------------------------------------------------
   logic sleepNop, goSleep, goIdle, irqTake, settleStart, settleDone, allReady;
   // pending irq makes sleep a no-op
   assign sleepNop = sleepInstr && pending_ff && state_ff == CPM_RUN;
   assign goSleep  = sleepInstr && !pending_ff && !idleSel_ff && state_ff == CPM_RUN;
   assign goIdle   = sleepInstr && !pending_ff && idleSel_ff && state_ff == CPM_RUN;
   assign allReady = flashReady && oscReady && (brownoutReady || brownoutDisabled);
   // run irq waits out a multicycle instruction
   assign irqTake = state_ff == CPM_RUN && pending_ff && !multiCycleBusy && !vecPend_ff;

   always_ff @(posedge clk) begin
      if (rst) begin
         state_ff <= CPM_RUN;
      end else begin
         case (state_ff)
            CPM_RUN: begin
               if (goSleep)     state_ff <= CPM_SLEEP;
               else if (goIdle) state_ff <= CPM_IDLE;
            end
            CPM_SLEEP: begin
               // wake goes via readiness; watchdog expiry resets
               if (wakeIrq)
                  state_ff <= lpSel_ff ? CPM_SETTLE : CPM_WREADY;
            end
            CPM_IDLE: begin
               if (wakeIrq || wdtTimeout) state_ff <= CPM_RUN;
            end
            CPM_SETTLE: begin
               if (settleDone) state_ff <= CPM_WREADY;
            end
            CPM_WREADY: begin
               if (allReady) state_ff <= CPM_RUN;
            end
            default: state_ff <= CPM_RUN;
         endcase
      end
   end
   assign settleStart = state_ff == CPM_SLEEP && wakeIrq && lpSel_ff;

   cpm_wake_delay u_settle (
      .clk   (clk),
      .rst   (rst),
      .start (settleStart),
      .done  (settleDone)
   );

   // vector after the prefetch unless an enable was cleared
   logic wakeToRun;
   assign wakeToRun = state_ff == CPM_WREADY && allReady;
   always_ff @(posedge clk) begin
      if (rst) begin
         vecPend_ff <= 1'b0;
         vectorReq  <= 1'b0;
      end else begin
         vectorReq <= 1'b0;
         if (vecPend_ff) begin
            vecPend_ff <= 1'b0;
            vectorReq  <= globalIrqEnable && !prefetchClrEn;
         end else if (irqTake || wakeToRun ||
                      (state_ff == CPM_IDLE && wakeIrq)) begin
            vecPend_ff <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // power status flags (active low)
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         pdN_ff <= 1'b1;
         toN_ff <= 1'b1;
      end else if (goSleep || (state_ff == CPM_SLEEP && wakeIrq)) begin
         pdN_ff <= 1'b0;
         toN_ff <= 1'b1;
      end
   end

   // watchdog clear on sleep entry and wake, not on no-op
   always_ff @(posedge clk) begin
      if (rst) wdtClr_ff <= 1'b0;
      else     wdtClr_ff <= goSleep || (state_ff == CPM_SLEEP && wakeIrq);
   end
   assign wdtClear = wdtClr_ff;
   assign wdtRun   = state_ff != CPM_SLEEP || wdtSleepRun;
   // watchdog reset suppressed in idle, becomes a wake
   assign wdtResetReq = wdtTimeout && state_ff != CPM_IDLE;

   // ------------------------------------------------------------
   // control register: doze enable has hardware set and clear
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         idleSel_ff      <= CPM_DOZE_RST[CPM_IDLE_BIT];
         recoverOnIrq_ff <= CPM_DOZE_RST[CPM_ROI_BIT];
         slowOnReturn_ff <= CPM_DOZE_RST[CPM_SOR_BIT];
         ratio_ff        <= CPM_DOZE_RST[CPM_RATIO_LSB +: CPM_RATIO_W];
      end else if (wrDoze) begin
         idleSel_ff      <= wData_ff[CPM_IDLE_BIT];
         recoverOnIrq_ff <= wData_ff[CPM_ROI_BIT];
         slowOnReturn_ff <= wData_ff[CPM_SOR_BIT];
         ratio_ff        <= wData_ff[CPM_RATIO_LSB +: CPM_RATIO_W];
      end
   end

   // hardware events beat a same-cycle write
   always_ff @(posedge clk) begin
      if (rst) begin
         dozeEn_ff <= CPM_DOZE_RST[CPM_DOZE_ENABLE_BIT];
      end else if (recoverOnIrq_ff && (irqTake ||
                   (state_ff == CPM_IDLE && wakeIrq))) begin
         dozeEn_ff <= 1'b0;
      end else if (retFromIrq && slowOnReturn_ff) begin
         dozeEn_ff <= 1'b1;
      end else if (wrDoze) begin
         dozeEn_ff <= wData_ff[CPM_DOZE_ENABLE_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         lpSel_ff <= CPM_LPSEL_RST;
         ien_ff   <= CPM_IEN_RST;
      end else begin
         if (wrVreg) lpSel_ff <= wData_ff[CPM_LPSEL_BIT];
         if (wrIen)  ien_ff   <= wData_ff[CPM_NIRQ-1:0];
      end
   end

   // ------------------------------------------------------------
   // clock gating outputs
   // ------------------------------------------------------------
   logic dozeCyc;
   cpm_doze_gen u_doze (
      .clk        (clk),
      .rst        (rst),
      .dozeOn     (dozeEn_ff),
      .ratioSel   (ratio_ff),
      .cpuCycleEn (dozeCyc)
   );
   assign cpuCycleEn   = dozeCyc && state_ff == CPM_RUN;
   assign cpuClkEn     = state_ff == CPM_RUN;
   assign flashFetchEn = state_ff == CPM_RUN;
   assign periphClkEn  = state_ff != CPM_SLEEP;
   assign ioHold       = state_ff == CPM_SLEEP;

   // ------------------------------------------------------------
   // axi read path
   // ------------------------------------------------------------
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge clk) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= CPM_RESP_OK;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= CPM_RESP_OK;
         case (s_axi_araddr)
            CPM_ADDR_DOZE: s_axi_rdata <= {24'h000000, idleSel_ff, dozeEn_ff,
                                           recoverOnIrq_ff, slowOnReturn_ff, 1'b0, ratio_ff};
            CPM_ADDR_VREG: s_axi_rdata <= CPM_VREG_RSVD | (32'(lpSel_ff) << CPM_LPSEL_BIT);
            CPM_ADDR_STAT: s_axi_rdata <= (32'(state_ff) << CPM_MODE_LSB) |
                                          (32'(toN_ff) << CPM_TO_BIT) |
                                          (32'(pdN_ff) << CPM_PD_BIT);
            CPM_ADDR_IEN:  s_axi_rdata <= 32'(ien_ff);
            default: begin
               s_axi_rdata <= '0;
               s_axi_rresp <= CPM_RESP_ERR;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule : cpm_power_ctrl

/* bench/cpm_power_ctrl_asserts.sv */
// cpu power-mode control: checks on top-level ports
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ps
module cpm_power_ctrl_asserts
   import cpm_pkg::*;
(
   input wire logic                clk, rst, cpuClkEn, periphClkEn, cpuCycleEn,
   input wire logic                flashFetchEn, ioHold, wdtClear, wdtRun, wdtSleepRun,
   input wire logic                wdtTimeout, wdtResetReq, vectorReq, flashReady,
   input wire logic                oscReady, brownoutReady, brownoutDisabled,
   input wire logic [CPM_NIRQ-1:0] irqFlag, clkSwitchMask
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // sleep edges each owe a watchdog clear
   sequence enterSleep; $rose(ioHold); endsequence
   sequence leaveSleep; $fell(ioHold); endsequence
   a_sleep_gates_cpu: assert property (ioHold |-> !cpuClkEn && !periphClkEn)
      else $error("clock alive in sleep");
   a_enter_clears_wdt: assert property (enterSleep |-> ##[0:1] wdtClear)
      else $error("no clear on entry");
   a_wake_clears_wdt: assert property (leaveSleep |-> ##[0:1] wdtClear)
      else $error("no clear on wake");
   a_sleep_wdt_run: assert property (ioHold |-> wdtRun == wdtSleepRun)
      else $error("watchdog run wrong");
   a_fetch_follows_cpu: assert property (flashFetchEn == cpuClkEn)
      else $error("fetch not tied to cpu");
   a_gated_no_cycle: assert property (!cpuClkEn |-> !cpuCycleEn)
      else $error("cycle while halted");
   a_resume_ready: assert property ($rose(cpuClkEn) |->
      flashReady && oscReady && (brownoutReady || brownoutDisabled))
      else $error("resumed too early");
   a_switch_no_wake: assert property (ioHold && !wdtTimeout
      && !(|(irqFlag & ~clkSwitchMask)) |=> ioHold)
      else $error("sleep left unwoken");
   a_wdt_reset_req: assert property (wdtTimeout && (cpuClkEn || ioHold) |-> wdtResetReq)
      else $error("no watchdog reset");
   a_vector_pulse: assert property (vectorReq |=> !vectorReq)
      else $error("vector too long");
endmodule : cpm_power_ctrl_asserts
bind cpm_power_ctrl cpm_power_ctrl_asserts cpm_power_ctrl_asserts_i (.*);

/* bench/cpm_ready_model.sv */
// readiness model: flash, oscillator, brown-out
// assumes ioHold marks sleep; brown-out settles last
`timescale 1ns/1ps
module cpm_ready_model #(parameter int DLY = 6) (
   input  wire logic clk, rst, ioHold,
   output logic      flashReady, oscReady, brownoutReady
);
   int cnt;   // cycles since wake
   // readiness drops in sleep, returns late
   always_ff @(posedge clk) begin
      if (rst || ioHold) cnt <= 0;
      else if (cnt < 2 * DLY) cnt <= cnt + 1;
   end
   assign flashReady    = !ioHold && cnt >= DLY;
   assign oscReady      = !ioHold && cnt >= DLY - 2;
   assign brownoutReady = !ioHold && cnt >= 2 * DLY;
endmodule : cpm_ready_model

/* bench/cpm_power_ctrl_test.sv */
// cpu power-mode control bench: axi4-lite tasks and mode tests
// assumes the readiness model on the far side and a 250 MHz clock
`timescale 1ns/1ps
module cpm_power_ctrl_test;
   import cpm_pkg::*;
   logic        clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, sleepInstr, retFromIrq, multiCycleBusy;
   logic        prefetchClrEn, globalIrqEnable, cpuCycleEn, cpuClkEn, flashFetchEn;
   logic        periphClkEn, vectorReq, ioHold, wdtTimeout, wdtSleepRun, wdtClear;
   logic        wdtRun, wdtResetReq, flashReady, oscReady, brownoutReady, brownoutDisabled;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, irqFlag, clkSwitchMask;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   int          errors, samples_checked, vecCnt, clrCnt, enCnt, n, v0;
   cpm_power_ctrl  cpm_power_ctrl_i (.*);
   cpm_ready_model cpm_ready_model_i (.*);
   initial begin
      clk = 0;
      forever #2 clk = ~clk;
   end
   // counters sample at negedge, clear of races
   always @(negedge clk) begin
      if (vectorReq === 1'b1) vecCnt++;
      if (wdtClear === 1'b1) clrCnt++;
      if (cpuCycleEn === 1'b1) enCnt++;
   end
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : test_done
   task automatic bound(input int k);  // a used-up wait ends the run
      if (k >= 400) begin
         errors++;
         test_done;
      end
   endtask : bound
   // aw and w offered together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int k; logic ta, tw, tb; logic [1:0] r;
      k = 0;
      tb = 0;
      @(posedge clk);
      {s_axi_awaddr, s_axi_wdata} <= {a, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      while (!tb && k < 400) begin
         @(negedge clk);
         {ta, tw, tb, r} = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp};
         @(posedge clk);
         if (ta) s_axi_awvalid <= 0;
         if (tw) s_axi_wvalid <= 0;
         k++;
      end
      s_axi_bready <= 0;
      chk("write response", r, CPM_RESP_OK);
      bound(k);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] re = CPM_RESP_OK);
      int k; logic ta, tv; logic [31:0] d; logic [1:0] r;
      k = 0;
      tv = 0;
      @(posedge clk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      while (!tv && k < 400) begin
         @(negedge clk);
         {ta, tv, d, r} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
         @(posedge clk);
         if (ta) s_axi_arvalid <= 0;
         k++;
      end
      s_axi_rready <= 0;
      chk("read data", d, e);
      chk("read response", r, re);
      bound(k);
   endtask : rd
   task automatic doSleep;
      @(posedge clk) sleepInstr <= 1;
      @(posedge clk) sleepInstr <= 0;
      repeat (3) @(negedge clk);
   endtask : doSleep
   task automatic toRun(output int k);  // cycles to cpu clock
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while (cpuClkEn !== 1'b1 && k < 400);
      bound(k);
   endtask : toRun
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, irqFlag, sleepInstr, retFromIrq} = '0;
      {multiCycleBusy, prefetchClrEn, globalIrqEnable, wdtTimeout, brownoutDisabled} = '0;
      {s_axi_wstrb, clkSwitchMask, wdtSleepRun, rst} = {4'hf, 8'h02, 2'b11};
      repeat (16) @(posedge clk);
      rst <= 0;
      rd(CPM_ADDR_DOZE, 32'h0);
      rd(CPM_ADDR_VREG, 32'h1);
      rd(CPM_ADDR_STAT, 32'h3);
      rd(8'h10, 32'h0, CPM_RESP_ERR);
      $display("reset test over");
      for (int s = 0; s < 8; s++) begin
         wr(CPM_ADDR_DOZE, 32'h40 | 32'(s));
         v0 = enCnt;
         repeat (512) @(posedge clk);
         chk("doze cycles", enCnt - v0, 512 >> (s + 1));
         chk("fetch periph", {flashFetchEn, periphClkEn}, 2'b11);
      end
      wr(CPM_ADDR_DOZE, 32'h0);
      wr(CPM_ADDR_IEN, 32'h3);
      $display("doze test over");
      @(posedge clk) irqFlag <= 8'h01;
      v0 = clrCnt;
      repeat (3) @(posedge clk);
      doSleep;
      chk("noop clears", clrCnt - v0, 0);
      @(posedge clk) irqFlag <= 8'h00;
      rd(CPM_ADDR_STAT, 32'h3);
      $display("noop test over");
      @(posedge clk) globalIrqEnable <= 1;
      v0 = clrCnt;
      doSleep;
      chk("sleep hold", {ioHold, cpuClkEn}, 2'b10);
      @(posedge clk) irqFlag <= 8'h02;
      repeat (10) @(negedge clk);
      chk("switch irq no wake", ioHold, 1'b1);
      chk("entry clear", clrCnt - v0, 1);
      v0 = vecCnt;
      @(posedge clk) irqFlag <= 8'h01;
      toRun(n);
      @(posedge clk) irqFlag <= 8'h00;
      repeat (4) @(negedge clk);
      chk("wake vector", vecCnt != v0, 1'b1);
      rd(CPM_ADDR_STAT, 32'h2);
      $display("wake test over");
      wr(CPM_ADDR_VREG, 32'h2);
      rd(CPM_ADDR_VREG, 32'h3);
      doSleep;
      @(posedge clk) irqFlag <= 8'h01;
      toRun(n);
      chk("settle delay", n >= CPM_LP_SETTLE_CYC, 1'b1);
      @(posedge clk) irqFlag <= 8'h00;
      wr(CPM_ADDR_DOZE, 32'he0);
      @(posedge clk) globalIrqEnable <= 0;
      doSleep;
      chk("idle clocks", {cpuClkEn, periphClkEn, ioHold}, 3'b010);
      @(posedge clk) irqFlag <= 8'h01;
      toRun(n);
      @(posedge clk) irqFlag <= 8'h00;
      rd(CPM_ADDR_DOZE, 32'ha0);
      wr(CPM_ADDR_DOZE, 32'hc0);
      doSleep;
      @(posedge clk) wdtTimeout <= 1;
      @(negedge clk) chk("idle watchdog reset", wdtResetReq, 1'b0);
      @(posedge clk) wdtTimeout <= 0;
      toRun(n);
      @(posedge clk) wdtTimeout <= 1;
      @(negedge clk) chk("wdt reset", wdtResetReq, 1'b1);
      @(posedge clk) wdtTimeout <= 0;
      rd(CPM_ADDR_DOZE, 32'hc0);
      $display("idle test over");
      wr(CPM_ADDR_DOZE, 32'h30);
      @(posedge clk) retFromIrq <= 1;
      @(posedge clk) retFromIrq <= 0;
      rd(CPM_ADDR_DOZE, 32'h70);
      v0 = vecCnt;
      @(posedge clk) {globalIrqEnable, prefetchClrEn, irqFlag} <= {2'b11, 8'h01};
      repeat (6) @(posedge clk);
      irqFlag <= 8'h00;
      rd(CPM_ADDR_DOZE, 32'h30);
      chk("vector skipped", vecCnt - v0, 0);
      $display("return test over");
      test_done;
   end
endmodule : cpm_power_ctrl_test
